/* pkg/qu_pkg.sv */
// Constants shared by both ends of the quad serial port pin link.
// Assumes one 125 MHz clock on each end and the 68-style host bus.
package qu_pkg;
  // ==========================================================================
  // Geometry.
  localparam int unsigned CHANNELS = 4;
  localparam int unsigned SYNC_W   = 38;

  // ==========================================================================
  // Register offsets inside a channel, addressed by the low three address lines.
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_CTL  = 3'h4;
  localparam logic [2:0] REG_LSR  = 3'h5;
  localparam logic [2:0] REG_STS  = 3'h6;

  // ==========================================================================
  // Field positions.
  localparam int unsigned CTL_DTR     = 0;
  localparam int unsigned CTL_RTS     = 1;
  localparam int unsigned LSR_RX_RDY  = 0;
  localparam int unsigned LSR_TX_EMPT = 5;
  localparam int unsigned STS_D_CTS   = 0;
  localparam int unsigned STS_D_DSR   = 1;
  localparam int unsigned STS_RI_END  = 2;
  localparam int unsigned STS_D_CD    = 3;
  localparam int unsigned STS_CTS     = 4;
  localparam int unsigned STS_DSR     = 5;
  localparam int unsigned STS_RI      = 6;
  localparam int unsigned STS_CD      = 7;

  // ==========================================================================
  // Values after reset.
  localparam logic [7:0] CTL_RST  = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ==========================================================================
  // Timing of one host strobe step and of the oscillator half period.
  localparam int unsigned CLK_NS        = 8;
  localparam int unsigned HOST_STEP_NS  = 80;
  localparam int unsigned HOST_STEP_CYC = (HOST_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OSC_HALF_CYC  = 2;
endpackage : qu_pkg

/* pkg/qu_if.sv */
// Pin bundle between the quad serial port and its host CPU plus modems.
// Assumes both ends share the clock; the data bus is resolved here.
`timescale 1ns/1ns
interface qu_if;
  logic       bus_16;
  logic       reset_pin;
  logic       cs_n;
  logic [4:0] reg_and_port_address;
  logic       rw_n;
  logic [7:0] host_dout;
  logic       host_oe_n;
  logic [7:0] dev_dout;
  logic       dev_oe_n;
  logic [7:0] data_bus;
  logic       any_rx_available_n;
  logic       any_tx_space_n;
  logic [3:0] cts_n;
  logic [3:0] dsr_n;
  logic [3:0] carrier_found_n;
  logic [3:0] ring_seen_n;
  logic [3:0] dtr_n;
  logic [3:0] rts_n;
  logic [3:0] ser_tx;
  logic [3:0] ser_rx;
  logic       osc_in;
  logic       osc_out;

  // An undriven bus floats high through its pull-up.
  assign data_bus = !dev_oe_n ? dev_dout : (!host_oe_n ? host_dout : 8'hff);

  modport dev (
    input  bus_16, reset_pin, cs_n, reg_and_port_address, rw_n, data_bus,
    input  cts_n, dsr_n, carrier_found_n, ring_seen_n, ser_rx, osc_in,
    output dev_dout, dev_oe_n, any_rx_available_n, any_tx_space_n,
    output dtr_n, rts_n, ser_tx, osc_out
  );
  modport host (
    output bus_16, reset_pin, cs_n, reg_and_port_address, rw_n, host_dout, host_oe_n,
    output cts_n, dsr_n, carrier_found_n, ring_seen_n, ser_rx, osc_in,
    input  data_bus, any_rx_available_n, any_tx_space_n, dtr_n, rts_n, ser_tx, osc_out
  );
endinterface : qu_if

/* rtl/qu_dev_end.sv */
// Device end of the quad serial port: 68-style register access, shared ready
// pins, per-channel modem lines and one-byte holding registers.
// Assumes the pins arrive asynchronously and a serial engine sits on the user side.
//
// Summary of operation
// - High reset pin in 16 mode resets all but the synchronisers and oscillator path.
// - Serial output and input held idle during reset.
// - In 68 mode reset pin acts low.
// - Strobe falling edge writes selected register.
// - Strobe rising edge drives selected register out.
// - Receive-ready pin low when any byte waits.
// - Receive-ready pin high when nothing waits.
// - Transmit-ready pin low when any space exists.
// - Transmit-ready pin high only when all full.
// - Per-channel receive status readable in registers.
// - Clear-to-send level shown in status bit 4.
// - Control bit 0 set drives terminal-ready low.
// - Control bit 0 clear drives terminal-ready high.
// - Data-set-ready and terminal-ready never touch serial data.
// - Modem pulls carrier-detect low on carrier.
// - Modem pulls data-set-ready low when ready.
// - Oscillator input serves as timing source.
// - Bus-style pin high picks 16 mode.
// - Control bit 1 drives request-to-send; high after reset.
// - Ring input rising edge flags modem status event.
`timescale 1ns/1ns
module qu_dev_end (
  input  wire logic        clock,
  input  wire logic        rst,
  qu_if.dev                pins,
  input  wire logic [3:0]  rx_push,
  input  wire logic [31:0] rx_push_data,
  input  wire logic [3:0]  tx_pop,
  output logic      [31:0] tx_data,
  output logic      [3:0]  tx_full,
  input  wire logic [3:0]  tx_line,
  output logic      [3:0]  rx_line,
  output logic      [3:0]  modem_event,
  output logic             baud_tick,
  output logic             reset_active
);
  // ==========================================================================
  // Input synchronisers.
  logic [qu_pkg::SYNC_W-1:0] sync_a;
  logic [qu_pkg::SYNC_W-1:0] sync_b;
  logic [qu_pkg::SYNC_W-1:0] raw_in;

  assign raw_in = {pins.bus_16, pins.reset_pin, pins.cs_n, pins.rw_n,
                   pins.reg_and_port_address, pins.data_bus, pins.cts_n, pins.dsr_n,
                   pins.carrier_found_n, pins.ring_seen_n, pins.ser_rx, pins.osc_in};

  // Two stages on every pin; only the second stage feeds logic.
  always_ff @(posedge clock) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  logic       bus_16_s;
  logic       reset_s;
  logic       cs_n_s;
  logic       rw_n_s;
  logic [4:0] addr_s;
  logic [7:0] data_s;
  logic [3:0] cts_n_s;
  logic [3:0] dsr_n_s;
  logic [3:0] cd_n_s;
  logic [3:0] ri_n_s;
  logic [3:0] ser_rx_s;
  logic       osc_s;

  assign {bus_16_s, reset_s, cs_n_s, rw_n_s, addr_s, data_s, cts_n_s, dsr_n_s,
          cd_n_s, ri_n_s, ser_rx_s, osc_s} = sync_b;

  // ==========================================================================
  // Reset pin polarity follows the bus style.
  logic pin_rst;
  logic dev_rst;

  assign pin_rst = bus_16_s ? reset_s : ~reset_s;
  assign dev_rst = rst | pin_rst;

  always_ff @(posedge clock) begin
    if (rst) begin
      reset_active <= 1'b1;
    end else begin
      reset_active <= pin_rst;
    end
  end

  // ==========================================================================
  // Strobe edges. The 16-style strobes are not built, so 16 mode leaves the bus idle.
  logic       rw_d;
  logic       wr_ev;
  logic       rd_ev;
  logic [1:0] sel_ch;
  logic [2:0] sel_reg;

  always_ff @(posedge clock) begin
    if (dev_rst) begin
      rw_d <= 1'b1;
    end else begin
      rw_d <= rw_n_s;
    end
  end

  assign sel_ch  = addr_s[4:3];
  assign sel_reg = addr_s[2:0];
  assign wr_ev   = rw_d & ~rw_n_s & ~cs_n_s & ~bus_16_s;
  assign rd_ev   = ~rw_d & rw_n_s & ~cs_n_s & ~bus_16_s;

  // ==========================================================================
  // Per-channel state.
  logic [7:0] rx_hold [qu_pkg::CHANNELS];
  logic [3:0] rx_full;
  logic [7:0] ctl     [qu_pkg::CHANNELS];
  logic [3:0] sts_d   [qu_pkg::CHANNELS];
  logic [3:0] lvl_d   [qu_pkg::CHANNELS];
  logic [7:0] sts     [qu_pkg::CHANNELS];
  logic [7:0] lsr     [qu_pkg::CHANNELS];

  // Receive holding register; a new byte wins over a read that empties it.
  // A byte pushed while full overwrites the old one, as there is no FIFO.
  always_ff @(posedge clock) begin
    for (int i = 0; i < qu_pkg::CHANNELS; i++) begin
      if (dev_rst) begin
        rx_full[i] <= 1'b0;
        rx_hold[i] <= qu_pkg::DATA_RST;
      end else if (rx_push[i]) begin
        rx_full[i] <= 1'b1;
        rx_hold[i] <= rx_push_data[8*i +: 8];
      end else if (rd_ev && sel_ch == 2'(i) && sel_reg == qu_pkg::REG_DATA) begin
        rx_full[i] <= 1'b0;
      end
    end
  end

  // Transmit holding register; a write while full is dropped.
  always_ff @(posedge clock) begin
    for (int i = 0; i < qu_pkg::CHANNELS; i++) begin
      if (dev_rst) begin
        tx_full[i]       <= 1'b0;
        tx_data[8*i +: 8] <= qu_pkg::DATA_RST;
      end else if (wr_ev && sel_ch == 2'(i) && sel_reg == qu_pkg::REG_DATA
                   && !tx_full[i]) begin
        tx_full[i]       <= 1'b1;
        tx_data[8*i +: 8] <= data_s;
      end else if (tx_pop[i]) begin
        tx_full[i] <= 1'b0;
      end
    end
  end

  // Modem control register and the lines it drives, one cycle behind the write.
  always_ff @(posedge clock) begin
    for (int i = 0; i < qu_pkg::CHANNELS; i++) begin
      if (dev_rst) begin
        ctl[i]        <= qu_pkg::CTL_RST;
        pins.dtr_n[i] <= 1'b1;
        pins.rts_n[i] <= 1'b1;
      end else begin
        if (wr_ev && sel_ch == 2'(i) && sel_reg == qu_pkg::REG_CTL) begin
          ctl[i] <= data_s;
        end
        pins.dtr_n[i] <= ~ctl[i][qu_pkg::CTL_DTR];
        pins.rts_n[i] <= ~ctl[i][qu_pkg::CTL_RTS];
      end
    end
  end

  // Modem status change flags. A new change wins over the clear done by a read.
  always_ff @(posedge clock) begin
    for (int i = 0; i < qu_pkg::CHANNELS; i++) begin
      if (dev_rst) begin
        sts_d[i]       <= 4'h0;
        lvl_d[i]       <= 4'hf;
        modem_event[i] <= 1'b0;
      end else begin
        lvl_d[i] <= {cd_n_s[i], ri_n_s[i], dsr_n_s[i], cts_n_s[i]};
        sts_d[i] <= ((rd_ev && sel_ch == 2'(i) && sel_reg == qu_pkg::REG_STS)
                     ? 4'h0 : sts_d[i])
                    | {cd_n_s[i] ^ lvl_d[i][3],
                       ri_n_s[i] & ~lvl_d[i][2],
                       dsr_n_s[i] ^ lvl_d[i][1],
                       cts_n_s[i] ^ lvl_d[i][0]};
        modem_event[i] <= |sts_d[i];
      end
    end
  end

  // Readable status images; modem bits show the asserted sense of each line.
  always_comb begin
    for (int i = 0; i < qu_pkg::CHANNELS; i++) begin
      sts[i]                     = 8'h00;
      sts[i][qu_pkg::STS_D_CTS]  = sts_d[i][0];
      sts[i][qu_pkg::STS_D_DSR]  = sts_d[i][1];
      sts[i][qu_pkg::STS_RI_END] = sts_d[i][2];
      sts[i][qu_pkg::STS_D_CD]   = sts_d[i][3];
      sts[i][qu_pkg::STS_CTS]    = ~cts_n_s[i];
      sts[i][qu_pkg::STS_DSR]    = ~dsr_n_s[i];
      sts[i][qu_pkg::STS_RI]     = ~ri_n_s[i];
      sts[i][qu_pkg::STS_CD]     = ~cd_n_s[i];
      lsr[i]                     = 8'h00;
      lsr[i][qu_pkg::LSR_RX_RDY] = rx_full[i];
      lsr[i][qu_pkg::LSR_TX_EMPT] = ~tx_full[i];
    end
  end

  // ==========================================================================
  // Read data path: latched on the rising strobe, driven until the host lets go.
  always_ff @(posedge clock) begin
    if (dev_rst) begin
      pins.dev_dout <= 8'h00;
      pins.dev_oe_n <= 1'b1;
    end else if (rd_ev) begin
      pins.dev_oe_n <= 1'b0;
      case (sel_reg)
        qu_pkg::REG_DATA: pins.dev_dout <= rx_hold[sel_ch];
        qu_pkg::REG_CTL:  pins.dev_dout <= ctl[sel_ch];
        qu_pkg::REG_LSR:  pins.dev_dout <= lsr[sel_ch];
        qu_pkg::REG_STS:  pins.dev_dout <= sts[sel_ch];
        default:          pins.dev_dout <= 8'h00;
      endcase
    end else if (cs_n_s || !rw_n_s) begin
      pins.dev_oe_n <= 1'b1;
    end
  end

  // ==========================================================================
  // Shared ready pins.
  always_ff @(posedge clock) begin
    if (dev_rst) begin
      pins.any_rx_available_n <= 1'b1;
      pins.any_tx_space_n     <= 1'b0;
    end else begin
      pins.any_rx_available_n <= ~|rx_full;
      pins.any_tx_space_n     <= &tx_full;
    end
  end

  // ==========================================================================
  // Serial lines held at idle mark while reset stands.
  always_ff @(posedge clock) begin
    if (dev_rst) begin
      pins.ser_tx <= 4'hf;
      rx_line     <= 4'hf;
    end else begin
      pins.ser_tx <= tx_line;
      rx_line     <= ser_rx_s;
    end
  end

  // Oscillator input: buffered back out and turned into a rate tick.
  logic osc_d;

  always_ff @(posedge clock) begin
    if (rst) begin
      osc_d        <= 1'b0;
      baud_tick    <= 1'b0;
      pins.osc_out <= 1'b0;
    end else begin
      osc_d        <= osc_s;
      baud_tick    <= osc_s & ~osc_d;
      pins.osc_out <= osc_s;
    end
  end
endmodule : qu_dev_end

/* rtl/qu_host_end.sv */
// Host CPU and modem end of the quad serial port link.
// Assumes the device samples pins through two flip-flops on its own clock.
`timescale 1ns/1ns
module qu_host_end (
  input  wire logic        clock,
  input  wire logic        rst,
  qu_if.host               pins,
  input  wire logic        mode_16,
  input  wire logic        reset_req,
  input  wire logic        req,
  input  wire logic        req_write,
  input  wire logic [4:0]  req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             busy,
  output logic             done,
  output logic      [7:0]  rdata,
  input  wire logic [3:0]  modem_cts_n,
  input  wire logic [3:0]  modem_dsr_n,
  input  wire logic [3:0]  modem_cd_n,
  input  wire logic [3:0]  modem_ri_n,
  input  wire logic [3:0]  modem_line,
  output logic      [13:0] seen
);
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_PRE  = 5'b00010,
    H_SEL  = 5'b00100,
    H_EDGE = 5'b01000,
    H_REL  = 5'b10000
  } qu_hstate_e;

  qu_hstate_e state;
  logic [7:0] step;
  logic       op_wr;
  logic       step_end;
  logic [7:0] d_a;
  logic [7:0] d_b;

  assign step_end = (step == 8'(qu_pkg::HOST_STEP_CYC - 1));

  // ==========================================================================
  // Read data passes two flops before capture.
  always_ff @(posedge clock) begin
    if (rst) begin
      d_a <= 8'h00;
      d_b <= 8'h00;
    end else begin
      d_a <= pins.data_bus;
      d_b <= d_a;
    end
  end

  // ==========================================================================
  // Strobe sequencer. Select drops only while the strobe stands still, so a
  // write never shows a rising edge under select and a read never a falling one.
  always_ff @(posedge clock) begin
    if (rst) begin
      state     <= H_IDLE;
      step      <= 8'h00;
      op_wr     <= 1'b0;
      busy      <= 1'b0;
      done      <= 1'b0;
      rdata     <= 8'h00;
      pins.cs_n <= 1'b1;
      pins.rw_n <= 1'b1;
      pins.reg_and_port_address <= 5'h00;
      pins.host_dout <= 8'h00;
      pins.host_oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      step <= (state == H_IDLE || step_end) ? 8'h00 : step + 8'h01;
      case (state)
        H_IDLE: begin
          if (req) begin
            busy  <= 1'b1;
            op_wr <= req_write;
            pins.reg_and_port_address <= req_addr;
            if (req_write) begin
              pins.cs_n      <= 1'b0;
              pins.host_dout <= req_wdata;
              pins.host_oe_n <= 1'b0;
              state          <= H_SEL;
            end else begin
              pins.rw_n <= 1'b0;
              state     <= H_PRE;
            end
          end
        end
        H_PRE: if (step_end) begin
          pins.cs_n <= 1'b0;
          state     <= H_SEL;
        end
        H_SEL: if (step_end) begin
          pins.rw_n <= ~op_wr;
          state     <= H_EDGE;
        end
        H_EDGE: if (step_end) begin
          if (!op_wr) begin
            rdata <= d_b;
          end
          pins.cs_n <= 1'b1;
          state     <= H_REL;
        end
        H_REL: if (step_end) begin
          pins.rw_n      <= 1'b1;
          pins.host_oe_n <= 1'b1;
          busy           <= 1'b0;
          done           <= 1'b1;
          state          <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Mode, reset pin and modem lines driven from flops.
  always_ff @(posedge clock) begin
    if (rst) begin
      pins.bus_16          <= 1'b0;
      pins.reset_pin       <= 1'b1;
      pins.cts_n           <= 4'hf;
      pins.dsr_n           <= 4'hf;
      pins.carrier_found_n <= 4'hf;
      pins.ring_seen_n     <= 4'hf;
      pins.ser_rx          <= 4'hf;
    end else begin
      pins.bus_16          <= mode_16;
      pins.reset_pin       <= mode_16 ? reset_req : ~reset_req;
      pins.cts_n           <= modem_cts_n;
      pins.dsr_n           <= modem_dsr_n;
      pins.carrier_found_n <= modem_cd_n;
      pins.ring_seen_n     <= modem_ri_n;
      pins.ser_rx          <= modem_line;
    end
  end

  // Oscillator source: a free divider that stands in for the crystal.
  logic [3:0] osc_cnt;

  always_ff @(posedge clock) begin
    if (rst) begin
      osc_cnt     <= 4'h0;
      pins.osc_in <= 1'b0;
    end else if (osc_cnt == 4'(qu_pkg::OSC_HALF_CYC - 1)) begin
      osc_cnt     <= 4'h0;
      pins.osc_in <= ~pins.osc_in;
    end else begin
      osc_cnt <= osc_cnt + 4'h1;
    end
  end

  // Device outputs seen by the host, synchronised.
  logic [13:0] seen_a;

  always_ff @(posedge clock) begin
    if (rst) begin
      seen_a <= 14'h3fff;
      seen   <= 14'h3fff;
    end else begin
      seen_a <= {pins.any_rx_available_n, pins.any_tx_space_n, pins.dtr_n,
                 pins.rts_n, pins.ser_tx};
      seen   <= seen_a;
    end
  end
endmodule : qu_host_end

/* verification/qu_monitor.sv */
// Concurrent checks on the pin bundle that joins the two ends of the quad serial port.
// Assumes one shared clock, a synchronous active high rst and the 68-style host bus.
`timescale 1ns/1ns
module qu_monitor (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       bus_16,
  input wire logic       reset_pin,
  input wire logic       cs_n,
  input wire logic [4:0] reg_and_port_address,
  input wire logic       rw_n,
  input wire logic       host_oe_n,
  input wire logic       dev_oe_n,
  input wire logic [7:0] dev_dout,
  input wire logic [7:0] data_bus,
  input wire logic       any_rx_available_n,
  input wire logic       any_tx_space_n,
  input wire logic [3:0] cts_n,
  input wire logic [3:0] dtr_n,
  input wire logic [3:0] rts_n,
  input wire logic [3:0] ser_tx,
  input wire logic       osc_in,
  input wire logic       osc_out
);
  // ==========================================================================
  // Shared timing.
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Reset behaviour. The pin reset needs a few cycles because the pins are synced first.
  // Its own disable overrides the default, which would make it vacuous.
  property p_rst_quiet;
    @(posedge clock) disable iff (1'b0) rst |=> (dtr_n == 4'hf && rts_n == 4'hf
      && ser_tx == 4'hf && dev_oe_n && any_rx_available_n && !any_tx_space_n);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not idle in reset");
  property p_pin_rst_68;
    (!bus_16 && !reset_pin) [*5] |=> (dtr_n == 4'hf && rts_n == 4'hf);
  endproperty
  a_pin_rst_68: assert property (p_pin_rst_68) else $error("low reset pin ignored");
  property p_pin_rst_16;
    (bus_16 && reset_pin) [*5] |=> (dtr_n == 4'hf && rts_n == 4'hf);
  endproperty
  a_pin_rst_16: assert property (p_pin_rst_16) else $error("high reset pin ignored");

  // ==========================================================================
  // Host bus cycles: the address must not move around a strobe edge.
  property p_addr_hold;
    (($fell(rw_n) || $rose(rw_n)) && !cs_n) |-> (!$past(cs_n, 3)
      && $past(reg_and_port_address, 3) == reg_and_port_address)
      ##1 (!cs_n && $stable(reg_and_port_address)) [*3];
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("select moved at strobe");
  property p_read_drive;
    $fell(dev_oe_n) |-> ($past(rw_n, 3) && !$past(cs_n, 3) && !$past(bus_16, 3));
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("bus driven without read");
  property p_one_driver;
    !(!dev_oe_n && !host_oe_n);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("both ends drive the bus");

  // ==========================================================================
  // Modem lines against the control and status registers, and the oscillator buffer path.
  sequence s_ctl_write;
    $fell(rw_n) && !cs_n && !host_oe_n && !bus_16 && reset_pin
      && reg_and_port_address[2:0] == qu_pkg::REG_CTL;
  endsequence
  property p_dtr_write;
    s_ctl_write |-> ##6 (dtr_n[reg_and_port_address[4:3]] == !data_bus[qu_pkg::CTL_DTR]);
  endproperty
  a_dtr_write: assert property (p_dtr_write) else $error("terminal ready wrong");
  property p_rts_write;
    s_ctl_write |-> ##6 (rts_n[reg_and_port_address[4:3]] == !data_bus[qu_pkg::CTL_RTS]);
  endproperty
  a_rts_write: assert property (p_rts_write) else $error("request to send wrong");
  property p_cts_level;
    ($fell(dev_oe_n) && reg_and_port_address[2:0] == qu_pkg::REG_STS
      && $past(cts_n, 4) == cts_n)
      |-> (dev_dout[qu_pkg::STS_CTS] == !cts_n[reg_and_port_address[4:3]]);
  endproperty
  a_cts_level: assert property (p_cts_level) else $error("clear to send bit wrong");
  property p_osc_follow;
    $rose(osc_in) |-> ##[1:3] $rose(osc_out);
  endproperty
  a_osc_follow: assert property (p_osc_follow) else $error("oscillator not followed");

  // ==========================================================================
  // Main scenarios reached.
  c_ctl_write: cover property (s_ctl_write);
  c_read: cover property ($fell(dev_oe_n));
  c_tx_full: cover property ($rose(any_tx_space_n));
  c_rx_wait: cover property ($fell(any_rx_available_n));
endmodule : qu_monitor

/* verification/tb_top.sv */
// Self-checking bench: both ends joined by one pin bundle, user sides driven here.
// Assumes the package and interface are compiled first; inputs move on the falling edge.
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic       wr;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
    logic [7:0] mask;
  } qu_row_s;

  logic clock, rst, mode_16, reset_req, req, req_write, busy, done, baud_tick, reset_active;
  logic [4:0]  req_addr;
  logic [7:0]  req_wdata, rdata, rd;
  logic [3:0]  modem_cts_n, modem_dsr_n, modem_cd_n, modem_ri_n, modem_line;
  logic [3:0]  rx_push, tx_pop, tx_full, tx_line, rx_line, modem_event;
  logic [31:0] rx_push_data, tx_data;
  logic [13:0] seen;
  int          errors, tests_run, n;

  // Ordinary accesses: write, address, write data, expected read, compared bits.
  qu_row_s rows [12] = '{
    '{1'b1, 5'h04, 8'h03, 8'h00, 8'h00}, '{1'b0, 5'h04, 8'h00, 8'h03, 8'h03},
    '{1'b1, 5'h1c, 8'h01, 8'h00, 8'h00}, '{1'b0, 5'h09, 8'h00, 8'h00, 8'hff},
    '{1'b0, 5'h06, 8'h00, 8'h30, 8'hf0}, '{1'b0, 5'h0e, 8'h00, 8'h00, 8'hf0},
    '{1'b0, 5'h16, 8'h00, 8'h90, 8'hf0}, '{1'b0, 5'h1e, 8'h00, 8'ha0, 8'hf0},
    '{1'b0, 5'h15, 8'h00, 8'h20, 8'h21}, '{1'b1, 5'h0f, 8'h55, 8'h00, 8'h00},
    '{1'b0, 5'h0f, 8'h00, 8'h00, 8'hff}, '{1'b1, 5'h04, 8'h02, 8'h00, 8'h00}};

  qu_if bus ();

  qu_dev_end i_qu_dev_end (.clock(clock), .rst(rst), .pins(bus), .rx_push(rx_push),
    .rx_push_data(rx_push_data), .tx_pop(tx_pop), .tx_data(tx_data), .tx_full(tx_full),
    .tx_line(tx_line), .rx_line(rx_line), .modem_event(modem_event), .baud_tick(baud_tick),
    .reset_active(reset_active));

  qu_host_end i_qu_host_end (.clock(clock), .rst(rst), .pins(bus), .mode_16(mode_16),
    .reset_req(reset_req), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata),
    .modem_cts_n(modem_cts_n), .modem_dsr_n(modem_dsr_n), .modem_cd_n(modem_cd_n),
    .modem_ri_n(modem_ri_n), .modem_line(modem_line), .seen(seen));

  qu_monitor i_qu_monitor (.clock(clock), .rst(rst), .bus_16(bus.bus_16),
    .reset_pin(bus.reset_pin), .cs_n(bus.cs_n), .reg_and_port_address(bus.reg_and_port_address),
    .rw_n(bus.rw_n), .host_oe_n(bus.host_oe_n), .dev_oe_n(bus.dev_oe_n),
    .dev_dout(bus.dev_dout), .data_bus(bus.data_bus),
    .any_rx_available_n(bus.any_rx_available_n), .any_tx_space_n(bus.any_tx_space_n),
    .cts_n(bus.cts_n), .dtr_n(bus.dtr_n), .rts_n(bus.rts_n), .ser_tx(bus.ser_tx),
    .osc_in(bus.osc_in), .osc_out(bus.osc_out));

  // ==========================================================================
  // Clock at 125 MHz.
  always #4 clock = ~clock;

  // ==========================================================================
  // Helpers.
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask : cyc

  // One host access; a missing done ends the run rather than hanging it.
  task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int k;
    @(negedge clock);
    req = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge clock);
    req = 1'b0;
    chk(busy, 1'b1);
    k = 0;
    while (done !== 1'b1 && k < 200) begin
      @(negedge clock);
      k++;
    end
    if (k >= 200) begin
      errors++;
      print_verdict();
    end
    q = rdata;
  endtask : acc

  // ==========================================================================
  // Main sequence: reset, table of accesses, then the awkward cases.
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    {mode_16, reset_req, req, req_write, req_addr, req_wdata} = '0;
    modem_cts_n = 4'b1010;
    modem_dsr_n = 4'b0110;
    modem_cd_n = 4'b0011;
    modem_ri_n = 4'hf;
    modem_line = 4'h9;
    {rx_push, rx_push_data, tx_pop} = '0;
    tx_line = 4'h5;
    errors = 0;
    tests_run = 0;
    cyc(3);
    chk({bus.dtr_n, bus.rts_n, bus.ser_tx}, 12'hfff);
    chk({bus.any_rx_available_n, bus.any_tx_space_n}, 2'b10);
    rst = 1'b0;
    cyc(12);
    chk(reset_active, 1'b0);
    foreach (rows[i]) begin
      acc(rows[i].wr, rows[i].addr, rows[i].wdata, rd);
      if (!rows[i].wr) chk(rd & rows[i].mask, rows[i].exp);
    end
    chk({bus.dtr_n, bus.rts_n}, 8'h7e);
    chk({bus.ser_tx, rx_line}, 8'h59);
    // Received byte pulls the shared pin low until it is read out.
    rx_push = 4'h4;
    rx_push_data = 32'h005a0000;
    cyc(1);
    rx_push = 4'h0;
    cyc(4);
    chk(bus.any_rx_available_n, 1'b0);
    acc(1'b0, 5'h15, 8'h00, rd);
    chk(rd[qu_pkg::LSR_RX_RDY], 1'b1);
    acc(1'b0, 5'h10, 8'h00, rd);
    chk(rd, 8'h5a);
    cyc(4);
    chk(bus.any_rx_available_n, 1'b1);
    // Fill every transmit holding register, then try one more write.
    for (int i = 0; i < 4; i++) acc(1'b1, 5'(i * 8), 8'(8'h10 + i), rd);
    acc(1'b1, 5'h00, 8'h77, rd);
    cyc(3);
    chk({tx_full, bus.any_tx_space_n}, 5'h1f);
    chk(tx_data, 32'h13121110);
    tx_pop = 4'h8;
    cyc(1);
    tx_pop = 4'h0;
    cyc(3);
    chk({tx_full, bus.any_tx_space_n}, 5'h0e);
    chk(seen, {bus.any_rx_available_n, bus.any_tx_space_n, bus.dtr_n, bus.rts_n,
               bus.ser_tx});
    // Ring pulse on channel 1 flags an event that a status read clears.
    modem_ri_n = 4'hd;
    cyc(6);
    modem_ri_n = 4'hf;
    cyc(6);
    chk(modem_event[1], 1'b1);
    acc(1'b0, 5'h0e, 8'h00, rd);
    chk(rd[qu_pkg::STS_RI_END], 1'b1);
    cyc(4);
    chk(modem_event[1], 1'b0);
    // Rate ticks follow the oscillator input, one per four cycles.
    n = 0;
    repeat (40) begin
      @(negedge clock);
      if (baud_tick === 1'b1) n++;
    end
    chk(n >= 9 && n <= 11, 1'b1);
    // In 16 mode the combined strobe does nothing, and a high reset pin resets.
    mode_16 = 1'b1;
    cyc(8);
    acc(1'b1, 5'h04, 8'h01, rd);
    cyc(8);
    chk(bus.dtr_n[0], 1'b1);
    reset_req = 1'b1;
    cyc(8);
    chk({reset_active, bus.dtr_n, bus.rts_n}, 9'h1ff);
    reset_req = 1'b0;
    mode_16 = 1'b0;
    cyc(10);
    chk(reset_active, 1'b0);
    acc(1'b1, 5'h14, 8'h01, rd);
    cyc(8);
    chk(bus.dtr_n[2], 1'b0);
    reset_req = 1'b1;
    cyc(8);
    chk({reset_active, bus.dtr_n[2]}, 2'b11);
    reset_req = 1'b0;
    cyc(10);
    print_verdict();
  end
endmodule : tb_top
